// >>> dv/gdm_host.sv
// Host model: command words, enable and PWM pins
`timescale 1ns/1ps
`default_nettype none
module gdm_host (
    input wire logic i_clock,
    output logic o_cmd_valid,
    output logic [15:0] o_cmd_word,
    output logic o_enable,
    output logic o_pwm_input
);
    // ========================================
    // Pin drivers, all moved at the falling edge
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_word = 16'h0000;
        o_enable = 1'b0;
        o_pwm_input = 1'b0;
    end
    // Idle word inverted so nothing leans on a stale word
    task automatic send(input logic [15:0] w);
        @(negedge i_clock);
        o_cmd_valid = 1'b1;
        o_cmd_word = w;
        @(negedge i_clock);
        o_cmd_valid = 1'b0;
        o_cmd_word = ~w;
    endtask
    task automatic pins(input logic en, input logic pwm);
        @(negedge i_clock);
        o_enable = en;
        o_pwm_input = pwm;
    endtask
endmodule // gdm_host
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the gate driver mode controller
`timescale 1ns/1ps
`default_nettype none
`include "gdm_params.svh"
module testbench;
    import gdm_pkg::*;
    localparam logic [15:0] C_EC = `GDM_CMD_ENTER_CONFIG;
    localparam logic [15:0] C_EV = `GDM_CMD_ENTER_VERIFY;
    localparam logic [15:0] C_LC = `GDM_CMD_LEAVE_CONFIG;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic secondary_oscillator = 1'b0;
    logic class_c = 1'b0;
    gdm_class_a_t class_a = '0;
    gdm_class_b_t class_b = '0;
    logic cmd_valid, enable, pwm, spi_error, a_err, b_err, a_fault_n, b_fault_n;
    logic gate_on, gate_weak, tristate, safe_off, reg_off, lockout, ready;
    logic [15:0] cmd_word;
    logic [2:0] mode;
    gdm_reg_write_t reg_write, wr;
    logic spi_seen;
    int err_count = 0;
    int cmp_count = 0;
    always #12.5 clock = ~clock;
    // Secondary oscillator free-running, phase unrelated to clock
    initial begin
        #37;
        forever #100 secondary_oscillator = ~secondary_oscillator;
    end
    gdm_host u_host (.i_clock(clock), .o_cmd_valid(cmd_valid), .o_cmd_word(cmd_word),
        .o_enable(enable), .o_pwm_input(pwm));
    gdm_mode_ctrl #(.VERIFY_TIMEOUT_CYCLES(32'd200)) u_dut (.i_clock(clock), .i_rst(rst),
        .i_cmd_valid(cmd_valid), .i_cmd_word(cmd_word), .i_enable(enable),
        .i_pwm_input(pwm), .i_secondary_oscillator(secondary_oscillator), .i_class_a(class_a), .i_class_b(class_b),
        .i_class_c(class_c), .o_mode_status_field(mode), .o_reg_write(reg_write),
        .o_spi_error(spi_error), .o_class_a_error(a_err), .o_class_b_error(b_err),
        .o_class_a_fault_n(a_fault_n), .o_class_b_fault_n(b_fault_n), .o_gate_on(gate_on),
        .o_gate_weak(gate_weak), .o_gate_tristate(tristate), .o_safe_turnoff(safe_off),
        .o_regular_turnoff(reg_off), .o_lockout(lockout), .o_reset_ready_pin(ready));
    // ========================================
    // One-cycle pulses caught over a short window
    always @(posedge clock) begin
        if (spi_error === 1'b1) spi_seen = 1'b1;
        if (reg_write.valid === 1'b1) wr = reg_write;
    end
    // ========================================
    // Checking and stimulus tasks
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic cm(input gdm_mode_t m);
        chk("mode", 16'(mode), 16'(m));
    endtask
    task automatic ce(input logic e);
        chk("spi error", 16'(spi_seen), 16'(e));
    endtask
    function automatic logic [15:0] wh(input logic [7:0] d);
        return 16'h4400 | (16'(d) << 1);
    endfunction
    function automatic logic [15:0] wl(input logic [4:0] a, input logic [5:0] d);
        return 16'ha000 | (16'(a) << 7) | (16'(d) << 1);
    endfunction
    task automatic cmd(input logic [15:0] w);
        spi_seen = 1'b0;
        wr = '0;
        u_host.send(w);
        repeat (3) @(negedge clock);
    endtask
    task automatic pins(input logic en, input logic p);
        u_host.pins(en, p);
        repeat (10) @(negedge clock);
    endtask
    task automatic ev(input gdm_class_a_t a, input gdm_class_b_t b, input logic c);
        @(negedge clock);
        spi_seen = 1'b0;
        class_a = a;
        class_b = b;
        class_c = c;
        repeat (3) @(negedge clock);
    endtask
    // Bounded wait for lockout expiry or for error mode
    task automatic wait_for(input logic err_mode);
        int i;
        for (i = 0; i < 4000; i++) begin
            if (err_mode ? mode === GDM_ERROR : lockout === 1'b0) break;
            @(negedge clock);
        end
        if (i == 4000) begin
            err_count++;
            print_verdict();
        end
    endtask
    // ========================================
    // Main sequence
    initial begin
        int b;
        repeat (4) @(negedge clock);
        chk("ready", 16'(ready), 16'h0);
        repeat (4) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        cm(GDM_DEFAULT);
        chk("ready", 16'(ready), 16'h1);
        chk("lock", 16'(lockout), 16'h1);
        chk("outs", 16'({a_fault_n, b_fault_n, gate_on}), 16'h6);
        cmd(C_LC);
        ce(1'b1);
        cmd(C_EV);
        ce(1'b1);
        cmd(wl(5'h05, 6'h01));
        ce(1'b1);
        chk("wr valid", 16'(wr.valid), 16'h0);
        cmd(wh(8'h5a));
        ce(1'b0);
        cm(GDM_DEFAULT);
        cmd(C_EC);
        cm(GDM_CONFIG);
        cmd(C_EC);
        ce(1'b1);
        cmd(wh(8'hab));
        cm(GDM_CONFIG);
        cmd(wl(5'h05, 6'h04));
        chk("wr addr", 16'(wr.addr), 16'h0005);
        chk("wr data", wr.data, 16'hab10);
        cmd(wl(5'h05, 6'h3f));
        chk("wr data", wr.data, 16'h00fc);
        cmd(wl(5'h10, 6'h01));
        ce(1'b1);
        wait_for(1'b0);
        cmd(C_EV);
        cm(GDM_VERIFY);
        pins(1'b1, 1'b1);
        cm(GDM_WEAK);
        chk("gate", 16'({gate_on, gate_weak}), 16'h1);
        ev(4'b0100, '0, 1'b0);
        chk("a off", 16'({safe_off, a_err, a_fault_n}), 16'h6);
        ev('0, '0, 1'b0);
        cm(GDM_VERIFY);
        chk("gate", 16'({gate_on, gate_weak}), 16'h0);
        wait_for(1'b1);
        chk("b fault", 16'(b_fault_n), 16'h0);
        for (b = 0; b < 5; b++) begin
            cmd(wl(`GDM_ADDR_PRIMARY_CTRL, 6'h04));
            chk("wr data", wr.data, 16'h0010);
            cm(GDM_DEFAULT);
            chk("b fault", 16'(b_fault_n), 16'h1);
            ev('0, 5'h01 << b, 1'b0);
            chk("b off", 16'({reg_off, b_err, b_fault_n}), 16'h6);
            cm(GDM_ERROR);
            ev('0, '0, 1'b0);
        end
        cmd(wl(`GDM_ADDR_PRIMARY_CTRL, 6'h04));
        cmd(C_EC);
        cmd(C_LC);
        cm(GDM_CONFIGURED);
        pins(1'b0, 1'b1);
        chk("gate", 16'(gate_on), 16'h0);
        wait_for(1'b0);
        pins(1'b1, 1'b1);
        cm(GDM_ACTIVE);
        chk("gate", 16'({gate_on, gate_weak}), 16'h2);
        ev('0, '0, 1'b1);
        ce(1'b1);
        ev('0, '0, 1'b0);
        cm(GDM_ACTIVE);
        ev(4'b1000, '0, 1'b0);
        chk("eto", 16'({safe_off, a_fault_n, lockout}), 16'h5);
        ev('0, '0, 1'b0);
        cm(GDM_CONFIGURED);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        cm(GDM_CONFIGURED);
        pins(1'b0, 1'b1);
        wait_for(1'b0);
        pins(1'b1, 1'b1);
        cm(GDM_ACTIVE);
        ev(4'b0010, '0, 1'b0);
        chk("tristate", 16'({tristate, a_fault_n, lockout}), 16'h6);
        ev('0, '0, 1'b0);
        cm(GDM_CONFIGURED);
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        ev(4'b0001, '0, 1'b0);
        chk("tristate", 16'({tristate, a_fault_n}), 16'h3);
        ev('0, '0, 1'b0);
        pins(1'b0, 1'b1);
        wait_for(1'b0);
        pins(1'b1, 1'b1);
        cm(GDM_ACTIVE);
        pins(1'b0, 1'b1);
        cm(GDM_CONFIGURED);
        chk("a fault", 16'(a_fault_n), 16'h0);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire

// >>> hw/gdm_mode_ctrl.sv
// Operating mode controller with staged register writes and fault outputs
`timescale 1ns/1ps
`default_nettype none
`include "gdm_params.svh"
module gdm_mode_ctrl #(
    parameter logic [31:0] VERIFY_TIMEOUT_CYCLES = `GDM_VERIFY_TIMEOUT_DEFAULT
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire logic [15:0] i_cmd_word,
    input wire logic i_enable,
    input wire logic i_pwm_input,
    input wire logic i_secondary_oscillator,
    input wire gdm_pkg::gdm_class_a_t i_class_a,
    input wire gdm_pkg::gdm_class_b_t i_class_b,
    input wire logic i_class_c,
    output logic [2:0] o_mode_status_field,
    output gdm_pkg::gdm_reg_write_t o_reg_write,
    output logic o_spi_error,
    output logic o_class_a_error,
    output logic o_class_b_error,
    output logic o_class_a_fault_n,
    output logic o_class_b_fault_n,
    output logic o_gate_on,
    output logic o_gate_weak,
    output logic o_gate_tristate,
    output logic o_safe_turnoff,
    output logic o_regular_turnoff,
    output logic o_lockout,
    output logic o_reset_ready_pin
);
    import gdm_pkg::*;

    // =====================================================
    // Input synchronisers
    logic [2:0] en_sync;
    logic [2:0] pwm_sync;
    logic [2:0] osc_sync;
    logic en_level;
    logic pwm_level;
    logic osc_level;
    logic en_prev;
    logic osc_prev;

    always_ff @(posedge i_clock) begin
        en_sync <= {en_sync[1:0], i_enable};
        pwm_sync <= {pwm_sync[1:0], i_pwm_input};
        osc_sync <= {osc_sync[1:0], i_secondary_oscillator};
    end

    // Level changes only once stages two and three agree
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            en_level <= 1'b0;
            pwm_level <= 1'b0;
            osc_level <= 1'b0;
        end else begin
            if (en_sync[1] == en_sync[2]) en_level <= en_sync[2];
            if (pwm_sync[1] == pwm_sync[2]) pwm_level <= pwm_sync[2];
            if (osc_sync[1] == osc_sync[2]) osc_level <= osc_sync[2];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            en_prev <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            en_prev <= en_level;
            osc_prev <= osc_level;
        end
    end

    wire en_rise = en_level & ~en_prev;
    wire en_fall = ~en_level & en_prev;
    wire osc_tick = osc_level & ~osc_prev;

    // =====================================================
    // Command decode
    gdm_mode_t mode;
    gdm_mode_t next_mode;
    logic [15:0] write_buffer;
    logic [31:0] verify_count;
    logic [8:0] lockout_count;

    wire is_enter_cfg = i_cmd_valid && (i_cmd_word == `GDM_CMD_ENTER_CONFIG);
    wire is_enter_ver = i_cmd_valid && (i_cmd_word == `GDM_CMD_ENTER_VERIFY);
    wire is_leave_cfg = i_cmd_valid && (i_cmd_word == `GDM_CMD_LEAVE_CONFIG);
    wire is_wr_high = i_cmd_valid &&
        ((i_cmd_word & `GDM_WRH_MASK) == `GDM_WRH_PATTERN);
    wire is_wr_low = i_cmd_valid &&
        ((i_cmd_word & `GDM_WRL_MASK) == `GDM_WRL_PATTERN);
    wire [7:0] wrh_data = i_cmd_word[`GDM_WRH_DATA_POS +: 8];
    wire [4:0] wrl_addr = i_cmd_word[`GDM_WRL_ADDR_POS +: 5];
    wire [5:0] wrl_data = i_cmd_word[`GDM_WRL_DATA_POS +: 6];
    wire [15:0] commit_word = {write_buffer[15:8], wrl_data, 2'b00};

    // Configuration space only while configuring; control register always
    wire wrl_allowed = (wrl_addr == `GDM_ADDR_PRIMARY_CTRL) ||
        ((mode == GDM_CONFIG) && (wrl_addr <= `GDM_CFG_ADDR_MAX));
    wire wrl_ok = is_wr_low && wrl_allowed;
    wire clear_sticky = wrl_ok && (wrl_addr == `GDM_ADDR_PRIMARY_CTRL) &&
        commit_word[`GDM_CLEAR_STICKY_POS];

    wire enter_cfg_ok = is_enter_cfg && ((mode == GDM_DEFAULT) || (mode == GDM_ERROR));
    wire enter_ver_ok = is_enter_ver && (mode == GDM_CONFIG);
    wire leave_cfg_ok = is_leave_cfg && (mode == GDM_CONFIG);
    wire cmd_reject = (is_enter_cfg && !enter_cfg_ok) || (is_enter_ver && !enter_ver_ok) ||
        (is_leave_cfg && !leave_cfg_ok) || (is_wr_low && !wrl_allowed);

    // =====================================================
    // Event classification
    wire verify_timeout = ((mode == GDM_VERIFY) || (mode == GDM_WEAK)) &&
        (verify_count >= VERIFY_TIMEOUT_CYCLES);
    wire safe_event = i_class_a.desaturation_event | i_class_a.overcurrent;
    wire tri_event = i_class_a.stage_tristate | i_class_a.shutdown_tristate;
    wire class_a = safe_event | en_fall | tri_event;
    wire class_b = (|i_class_b) | verify_timeout;
    wire enabled = (mode == GDM_ACTIVE) || (mode == GDM_WEAK);
    wire a_moves = class_a && enabled && !class_b;
    wire b_moves = class_b && (mode != GDM_ERROR);
    // A tristate arriving with a turn-off cause must not hide that cause
    wire eto_start = safe_event | en_fall | class_b;

    // =====================================================
    // Mode state machine; class C input is never looked at here
    always_comb begin
        next_mode = mode;
        if (class_b) begin
            next_mode = GDM_ERROR;
        end else if (class_a) begin
            case (mode)
                GDM_ACTIVE: next_mode = GDM_CONFIGURED;
                GDM_WEAK: next_mode = GDM_VERIFY;
                default: next_mode = mode;
            endcase
        end else begin
            case (mode)
                GDM_DEFAULT: if (enter_cfg_ok) next_mode = GDM_CONFIG;
                GDM_ERROR: begin
                    if (enter_cfg_ok) next_mode = GDM_CONFIG;
                    else if (clear_sticky) next_mode = GDM_DEFAULT;
                end
                GDM_CONFIG: begin
                    if (leave_cfg_ok) next_mode = GDM_CONFIGURED;
                    else if (enter_ver_ok) next_mode = GDM_VERIFY;
                end
                // Re-enable refused while the lockout runs
                GDM_CONFIGURED: if (en_rise && lockout_count == 9'd0) next_mode = GDM_ACTIVE;
                GDM_VERIFY: if (en_rise && lockout_count == 9'd0) next_mode = GDM_WEAK;
                GDM_ACTIVE: next_mode = mode;
                GDM_WEAK: next_mode = mode;
                default: next_mode = GDM_DEFAULT;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) mode <= GDM_DEFAULT;
        else mode <= next_mode;
    end

    // Watchdog runs across verification and weak active, cleared elsewhere
    always_ff @(posedge i_clock) begin
        if (i_rst) verify_count <= 32'd0;
        else if (mode == GDM_VERIFY || mode == GDM_WEAK) verify_count <= verify_count + 32'd1;
        else verify_count <= 32'd0;
    end

    // Counted on secondary oscillator rising edges, restarted on every turn-off
    always_ff @(posedge i_clock) begin
        if (i_rst) lockout_count <= `GDM_LOCKOUT_OSC_CYCLES;
        else if (eto_start) lockout_count <= `GDM_LOCKOUT_OSC_CYCLES;
        else if (osc_tick && lockout_count != 9'd0) lockout_count <= lockout_count - 9'd1;
    end

    // =====================================================
    // Write buffer
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            write_buffer <= `GDM_BUFFER_RESET;
        end else if (wrl_ok) begin
            write_buffer <= `GDM_BUFFER_RESET;
        end else if (is_wr_high) begin
            write_buffer[15:8] <= wrh_data;
        end
    end

    // Class A never writes configuration; only legal commits do
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_reg_write <= '0;
        end else begin
            o_reg_write.valid <= wrl_ok;
            o_reg_write.addr <= wrl_addr;
            o_reg_write.data <= commit_word;
        end
    end

    // =====================================================
    // Outputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_spi_error <= 1'b0;
            o_class_a_error <= 1'b0;
            o_class_b_error <= 1'b0;
            o_class_a_fault_n <= 1'b1;
            o_class_b_fault_n <= 1'b1;
            o_safe_turnoff <= 1'b0;
            o_regular_turnoff <= 1'b0;
            o_gate_tristate <= 1'b0;
        end else begin
            o_spi_error <= cmd_reject | i_class_c;
            o_class_a_error <= class_a;
            o_class_b_error <= class_b;
            // Class A fault asserted with a safe or enable-fall transition, held until re-enabled; class B fault held until error is left
            if (a_moves && (safe_event || en_fall)) o_class_a_fault_n <= 1'b0;
            else if (next_mode == GDM_ACTIVE || next_mode == GDM_WEAK) o_class_a_fault_n <= 1'b1;
            if (b_moves) o_class_b_fault_n <= 1'b0;
            else if (mode == GDM_ERROR && next_mode != GDM_ERROR) o_class_b_fault_n <= 1'b1;
            o_safe_turnoff <= safe_event;
            o_regular_turnoff <= !safe_event && (en_fall || class_b);
            o_gate_tristate <= tri_event;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_mode_status_field <= 3'h0;
            o_gate_on <= 1'b0;
            o_gate_weak <= 1'b0;
            o_lockout <= 1'b1;
            o_reset_ready_pin <= 1'b0;
        end else begin
            o_mode_status_field <= next_mode;
            o_gate_on <= (next_mode == GDM_ACTIVE) && pwm_level;
            o_gate_weak <= (next_mode == GDM_WEAK) && pwm_level;
            o_lockout <= (lockout_count != 9'd0);
            o_reset_ready_pin <= 1'b1;
        end
    end

    // =====================================================
    // Checks
    chk_gate_only_active: assert property (@(posedge i_clock) disable iff (i_rst)
        o_gate_on |-> (o_mode_status_field == GDM_ACTIVE))
        else $error("Gate on outside active mode");
    chk_weak_only_weak: assert property (@(posedge i_clock) disable iff (i_rst)
        o_gate_weak |-> (o_mode_status_field == GDM_WEAK))
        else $error("Weak turn-on outside weak active mode");
    chk_class_a_drop: assert property (@(posedge i_clock) disable iff (i_rst)
        (mode == GDM_ACTIVE && class_a && !class_b) |=> (mode == GDM_CONFIGURED))
        else $error("Class A did not leave active mode");
    chk_class_a_stay: assert property (@(posedge i_clock) disable iff (i_rst)
        (class_a && !enabled && !class_b) |=> $stable(mode))
        else $error("Class A changed a disabled mode");
    chk_class_b_error: assert property (@(posedge i_clock) disable iff (i_rst)
        class_b |=> (mode == GDM_ERROR && o_class_b_error))
        else $error("Class B did not enter error mode");
    chk_fault_a_cause: assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(o_class_a_fault_n) |-> (($past(mode) == GDM_ACTIVE && mode == GDM_CONFIGURED) ||
        ($past(mode) == GDM_WEAK && mode == GDM_VERIFY)))
        else $error("Class A fault without mode drop");
    chk_fault_b_cause: assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(o_class_b_fault_n) |-> ($past(mode) != GDM_ERROR && mode == GDM_ERROR))
        else $error("Class B fault without transition");
    chk_no_write_on_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (class_a && !wrl_ok) |=> !o_reg_write.valid)
        else $error("Class A wrote a register");
    chk_buffer_cleared: assert property (@(posedge i_clock) disable iff (i_rst)
        wrl_ok |=> (write_buffer == 16'h0000 && o_reg_write.valid))
        else $error("Buffer not cleared after commit");
    chk_high_byte_load: assert property (@(posedge i_clock) disable iff (i_rst)
        (is_wr_high && !wrl_ok && !class_a && !class_b && !en_rise) |=>
        (write_buffer[15:8] == $past(wrh_data) && $stable(mode)))
        else $error("High byte write misbehaved");
    chk_bad_cmd_error: assert property (@(posedge i_clock) disable iff (i_rst)
        (is_enter_ver && mode != GDM_CONFIG) |=> o_spi_error)
        else $error("Invalid command raised no SPI error");
    chk_enter_cfg_move: assert property (@(posedge i_clock) disable iff (i_rst)
        (enter_cfg_ok && !class_a && !class_b) |=> (mode == GDM_CONFIG))
        else $error("Enter config did not reach configuration mode");
    chk_leave_cfg_move: assert property (@(posedge i_clock) disable iff (i_rst)
        (leave_cfg_ok && !class_a && !class_b) |=> (mode == GDM_CONFIGURED))
        else $error("Leave config did not reach configured mode");
    chk_clear_sticky_move: assert property (@(posedge i_clock) disable iff (i_rst)
        (clear_sticky && mode == GDM_ERROR && !class_a && !class_b) |=> (mode == GDM_DEFAULT))
        else $error("Clear sticky did not leave error mode");
    chk_class_c_mode: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_class_c && !i_cmd_valid && !class_a && !class_b && !en_rise) |=> $stable(mode))
        else $error("Class C changed mode");
    chk_lockout_refuse: assert property (@(posedge i_clock) disable iff (i_rst)
        (mode == GDM_CONFIGURED && lockout_count != 9'd0) |=> (mode != GDM_ACTIVE))
        else $error("Re-enabled during lockout");
    chk_tristate_no_eto: assert property (@(posedge i_clock) disable iff (i_rst)
        (tri_event && !safe_event && !en_fall && !class_b && lockout_count == 9'd0) |=>
        (lockout_count == 9'd0))
        else $error("Tristate alone restarted the lockout");
    // Reset checks carry no disable, they must see reset itself
    chk_reset_state: assert property (@(posedge i_clock)
        i_rst |=> (mode == GDM_DEFAULT && write_buffer == 16'h0000 && !o_gate_on))
        else $error("Reset left state behind");
    chk_ready_high: assert property (@(posedge i_clock)
        !i_rst |=> o_reset_ready_pin)
        else $error("Ready pin low outside reset");

    // =====================================================
    // Cover points
    cov_reach_active: cover property (@(posedge i_clock) mode == GDM_ACTIVE);
    cov_reach_weak: cover property (@(posedge i_clock) mode == GDM_WEAK);
    cov_error_mode: cover property (@(posedge i_clock) $rose(mode == GDM_ERROR));
    cov_clear_sticky: cover property (@(posedge i_clock) clear_sticky && mode == GDM_ERROR);
    cov_lockout_refused: cover property (@(posedge i_clock)
        mode == GDM_CONFIGURED && en_rise && lockout_count != 9'd0);

endmodule // gdm_mode_ctrl
`default_nettype wire

// >>> hw/gdm_params.svh
// Constants of the gate driver mode controller
`ifndef GDM_PARAMS_SVH
`define GDM_PARAMS_SVH

// =====================================================
// Command words and fields
`define GDM_CMD_ENTER_CONFIG 16'h1880
`define GDM_CMD_ENTER_VERIFY 16'h1140
`define GDM_CMD_LEAVE_CONFIG 16'h1220
`define GDM_WRH_PATTERN 16'h4400
`define GDM_WRH_MASK 16'hfe00
`define GDM_WRL_PATTERN 16'ha000
`define GDM_WRL_MASK 16'hf000
`define GDM_WRL_ADDR_POS 7
`define GDM_WRL_DATA_POS 1
`define GDM_WRH_DATA_POS 1

// =====================================================
// Register map used by the low-byte commit
`define GDM_ADDR_PRIMARY_CTRL 5'h02
`define GDM_CLEAR_STICKY_POS 4
`define GDM_CFG_ADDR_MAX 5'h0f
`define GDM_BUFFER_RESET 16'h0000

// =====================================================
// Timing
`define GDM_LOCKOUT_OSC_CYCLES 9'd256
`define GDM_VERIFY_TIMEOUT_DEFAULT 32'd400000

`endif

// >>> hw/gdm_pkg.sv
// Types of the gate driver mode controller
package gdm_pkg;

    // Gray-coded along default, config, configured, active
    typedef enum logic [2:0] {
        GDM_DEFAULT = 3'h0,
        GDM_CONFIG = 3'h1,
        GDM_CONFIGURED = 3'h3,
        GDM_ACTIVE = 3'h2,
        GDM_VERIFY = 3'h6,
        GDM_WEAK = 3'h7,
        GDM_ERROR = 3'h5
    } gdm_mode_t;

    typedef struct packed {
        logic desaturation_event;
        logic overcurrent;
        logic stage_tristate;
        logic shutdown_tristate;
    } gdm_class_a_t;

    typedef struct packed {
        logic supply2_under;
        logic supply2_over;
        logic supply3_under;
        logic supply3_over;
        logic supervision;
    } gdm_class_b_t;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [15:0] data;
    } gdm_reg_write_t;

endpackage
